// *** uisd_pkg.sv ***
package uisd_pkg;
	// Register byte addresses on the APB bus
	localparam logic [11:0] UISD_ADDR_MASK     = 12'h038;
	localparam logic [11:0] UISD_ADDR_RAW      = 12'h03c;
	localparam logic [11:0] UISD_ADDR_MASKED   = 12'h040;
	localparam logic [11:0] UISD_ADDR_CLEAR    = 12'h044;
	localparam logic [11:0] UISD_ADDR_DMA      = 12'h048;
	localparam logic [11:0] UISD_ADDR_FIFO_LVL = 12'h034;

	// Interrupt field layout
	localparam int UISD_NUM_IRQ = 11;
	localparam int UISD_BIT_OVERRUN = 10;
	localparam int UISD_BIT_BREAK   = 9;
	localparam int UISD_BIT_PARITY  = 8;
	localparam int UISD_BIT_FRAMING = 7;
	localparam int UISD_BIT_RX_TO   = 6;
	localparam int UISD_BIT_TX      = 5;
	localparam int UISD_BIT_RX      = 4;
	localparam int UISD_BIT_DSR     = 3;
	localparam int UISD_BIT_DCD     = 2;
	localparam int UISD_BIT_CTS     = 1;
	localparam int UISD_BIT_RING    = 0;
	localparam logic [10:0] UISD_ERR_MASK = 11'h780;

	// DMA control fields
	localparam int UISD_DMA_WIDTH = 3;
	localparam int UISD_BIT_RX_DMA_EN  = 0;
	localparam int UISD_BIT_TX_DMA_EN  = 1;
	localparam int UISD_BIT_DMA_ON_ERR = 2;

	// FIFO level select fields and reset values
	localparam int UISD_LVL_WIDTH = 6;
	localparam int UISD_FIFO_CNT_W = 5;
	localparam logic [5:0]  UISD_LVL_RESET  = 6'h12;
	localparam logic [10:0] UISD_IRQ_RESET  = 11'h000;
	localparam logic [10:0] UISD_MASK_RESET = 11'h000;
	localparam logic [2:0]  UISD_DMA_RESET  = 3'h0;
	localparam logic [4:0]  UISD_FIFO_DEPTH = 5'h10;
endpackage : uisd_pkg

// *** uisd_level_cross.sv ***
`timescale 1ns/1ps
// Pulses when a FIFO fill level passes through its trigger point
module uisd_level_cross (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Fill level and trigger
	input  wire logic [4:0] fill_level,
	input  wire logic [2:0] level_select,
	input  wire logic       trigger_below,
	// Event out
	output logic            cross_pulse
);
	import uisd_pkg::*;

	logic [4:0] prev_level_ff;
	logic [4:0] trig_level;
	logic       now_beyond;
	logic       was_beyond;

	// Trigger point in eighths of the FIFO depth; reserved codes act as half
	always_comb begin
		case (level_select)
			3'h0:    trig_level = UISD_FIFO_DEPTH >> 3;
			3'h1:    trig_level = UISD_FIFO_DEPTH >> 2;
			3'h2:    trig_level = UISD_FIFO_DEPTH >> 1;
			3'h3:    trig_level = 5'((UISD_FIFO_DEPTH >> 1) + (UISD_FIFO_DEPTH >> 2));
			3'h4:    trig_level = 5'(UISD_FIFO_DEPTH - (UISD_FIFO_DEPTH >> 3));
			default: trig_level = UISD_FIFO_DEPTH >> 1;
		endcase
	end

	// Beyond means at or past the trigger in the direction of interest
	assign now_beyond = trigger_below ? (fill_level <= trig_level) : (fill_level >= trig_level);
	assign was_beyond = trigger_below ? (prev_level_ff <= trig_level)
	                                  : (prev_level_ff >= trig_level);
	assign cross_pulse = now_beyond && !was_beyond; // RULE13

	// Previous fill level, reset to the halfway reset trigger so no false crossing follows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_level_ff <= UISD_FIFO_DEPTH >> 1;
		end else begin
			prev_level_ff <= fill_level;
		end
	end
endmodule : uisd_level_cross

// *** uisd_dma_gate.sv ***
`timescale 1ns/1ps
// Gates receive and transmit DMA requests by the control bits
module uisd_dma_gate (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control and state
	input  wire logic [2:0] dma_ctrl,
	input  wire logic       error_irq,
	// Raw requests from the FIFOs
	input  wire logic       rx_single_raw,
	input  wire logic       rx_burst_raw,
	input  wire logic       tx_single_raw,
	input  wire logic       tx_burst_raw,
	// Requests to the DMA controller
	output logic            rx_dma_single_request,
	output logic            rx_dma_burst_request,
	output logic            tx_dma_single_request,
	output logic            tx_dma_burst_request
);
	import uisd_pkg::*;

	logic rx_allow;
	logic tx_allow;

	// Receive requests need enable and no blocking error
	assign rx_allow = dma_ctrl[UISD_BIT_RX_DMA_EN] // RULE9
	                  && !(dma_ctrl[UISD_BIT_DMA_ON_ERR] && error_irq); // RULE11
	assign tx_allow = dma_ctrl[UISD_BIT_TX_DMA_EN]; // RULE10

	// Registered request outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_dma_single_request <= 1'b0;
			rx_dma_burst_request  <= 1'b0;
			tx_dma_single_request <= 1'b0;
			tx_dma_burst_request  <= 1'b0;
		end else begin
			rx_dma_single_request <= rx_allow && rx_single_raw;
			rx_dma_burst_request  <= rx_allow && rx_burst_raw;
			tx_dma_single_request <= tx_allow && tx_single_raw;
			tx_dma_burst_request  <= tx_allow && tx_burst_raw;
		end
	end
endmodule : uisd_dma_gate

// *** uisd_top.sv ***
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// RULE1: Raw status is read-only; reads give unmasked state, writes change nothing.
// RULE2: Reset clears all status bits; modem bits 3..0 cleared here too.
// RULE3: Bits: 10 overrun, 9 break, 8 parity, 7 framing, 6 timeout, 5 tx, 4 rx, 3..0 modem.
// RULE4: Bits 15..11 of raw, masked and clear registers read as zero.
// RULE5: Masked status is read-only, raw bits after mask, same positions.
// RULE6: Clear register is write-only; a one clears, a zero leaves alone.
// RULE7: Each clear bit acts on the status bit at the same position.
// RULE8: DMA control is read/write, zero after reset, bits 15..3 read zero.
// RULE9: DMA control bit 0 enables receive DMA requests.
// RULE10: DMA control bit 1 enables transmit DMA requests.
// RULE11: DMA control bit 2 blocks receive requests while error interrupt is high.
// RULE12: Mask register is read/write, reset zero, reads return current mask.
// RULE13: FIFO interrupts fire when the fill level passes the trigger point.
// RULE14: Masked status equals raw status AND mask bit.
module uisd_top (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt source events from the UART core
	input  wire logic        overrun_irq,
	input  wire logic        break_irq,
	input  wire logic        parity_irq,
	input  wire logic        framing_irq,
	input  wire logic        rx_timeout_irq,
	input  wire logic        dsr_change_irq,
	input  wire logic        dcd_change_irq,
	input  wire logic        cts_change_irq,
	input  wire logic        ring_change_irq,
	// FIFO fill levels
	input  wire logic [4:0]  tx_fill_level,
	input  wire logic [4:0]  rx_fill_level,
	// Raw DMA requests from the FIFOs
	input  wire logic        rx_single_raw,
	input  wire logic        rx_burst_raw,
	input  wire logic        tx_single_raw,
	input  wire logic        tx_burst_raw,
	// DMA requests
	output logic             rx_dma_single_request,
	output logic             rx_dma_burst_request,
	output logic             tx_dma_single_request,
	output logic             tx_dma_burst_request,
	// Interrupt outputs
	output logic             uart_irq,
	output logic             error_irq
);
	import uisd_pkg::*;

	logic [10:0] raw_status_ff;
	logic [10:0] nxt_raw_status;
	logic [10:0] mask_ff;
	logic [2:0]  dma_ctrl_ff;
	logic [5:0]  fifo_lvl_ff;
	logic [10:0] masked_status;
	logic [10:0] events;
	logic [10:0] clear_bits;
	logic        tx_cross;
	logic        rx_cross;
	logic        wr_access;
	logic        rd_setup;
	logic [31:0] nxt_prdata;
	logic        addr_ok;

	// Decode whether an address hits a mapped register
	function automatic logic uisd_hit(input logic [11:0] addr);
		uisd_hit = (addr == UISD_ADDR_MASK) || (addr == UISD_ADDR_RAW) ||
		           (addr == UISD_ADDR_MASKED) || (addr == UISD_ADDR_CLEAR) ||
		           (addr == UISD_ADDR_DMA) || (addr == UISD_ADDR_FIFO_LVL);
	endfunction : uisd_hit

	// FIFO threshold crossing detectors
	uisd_level_cross u_tx_cross (
		.pclk          (pclk),
		.presetn       (presetn),
		.fill_level    (tx_fill_level),
		.level_select  (fifo_lvl_ff[2:0]),
		.trigger_below (1'b1),
		.cross_pulse   (tx_cross)
	);

	uisd_level_cross u_rx_cross (
		.pclk          (pclk),
		.presetn       (presetn),
		.fill_level    (rx_fill_level),
		.level_select  (fifo_lvl_ff[5:3]),
		.trigger_below (1'b0),
		.cross_pulse   (rx_cross)
	);

	// Event vector in status bit order
	always_comb begin
		events = '0;
		events[UISD_BIT_OVERRUN] = overrun_irq; // RULE3
		events[UISD_BIT_BREAK]   = break_irq;
		events[UISD_BIT_PARITY]  = parity_irq;
		events[UISD_BIT_FRAMING] = framing_irq;
		events[UISD_BIT_RX_TO]   = rx_timeout_irq;
		events[UISD_BIT_TX]      = tx_cross; // RULE13
		events[UISD_BIT_RX]      = rx_cross; // RULE13
		events[UISD_BIT_DSR]     = dsr_change_irq;
		events[UISD_BIT_DCD]     = dcd_change_irq;
		events[UISD_BIT_CTS]     = cts_change_irq;
		events[UISD_BIT_RING]    = ring_change_irq;
	end

	// Bus strobes; a write takes effect in the access phase
	assign wr_access = psel && penable && pwrite && pready;
	assign rd_setup  = psel && !penable && !pwrite;
	assign addr_ok   = uisd_hit(paddr);

	// Clear bits from a clear register write, same position as status
	assign clear_bits = (wr_access && paddr == UISD_ADDR_CLEAR) ? pwdata[10:0] // RULE6 RULE7
	                                                            : 11'h000;

	// Sticky status: a new event wins over a clear in the same cycle
	assign nxt_raw_status = (raw_status_ff & ~clear_bits) | events; // RULE6

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_status_ff <= UISD_IRQ_RESET; // RULE2
		end else begin
			raw_status_ff <= nxt_raw_status; // RULE1
		end
	end

	// Mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_ff <= UISD_MASK_RESET; // RULE12
		end else if (wr_access && paddr == UISD_ADDR_MASK) begin
			mask_ff <= pwdata[10:0]; // RULE12
		end
	end

	// DMA control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_ctrl_ff <= UISD_DMA_RESET; // RULE8
		end else if (wr_access && paddr == UISD_ADDR_DMA) begin
			dma_ctrl_ff <= pwdata[2:0]; // RULE8
		end
	end

	// FIFO level select register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_lvl_ff <= UISD_LVL_RESET;
		end else if (wr_access && paddr == UISD_ADDR_FIFO_LVL) begin
			fifo_lvl_ff <= pwdata[5:0];
		end
	end

	// Masked view of the status
	assign masked_status = raw_status_ff & mask_ff; // RULE14 RULE5

	// Read data mux; upper bits read as zero
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		case (paddr)
			UISD_ADDR_MASK:     nxt_prdata = {21'h0, mask_ff}; // RULE12
			UISD_ADDR_RAW:      nxt_prdata = {21'h0, raw_status_ff}; // RULE1 RULE4
			UISD_ADDR_MASKED:   nxt_prdata = {21'h0, masked_status}; // RULE5 RULE4
			UISD_ADDR_DMA:      nxt_prdata = {29'h0, dma_ctrl_ff}; // RULE8
			UISD_ADDR_FIFO_LVL: nxt_prdata = {26'h0, fifo_lvl_ff};
			default:            nxt_prdata = 32'h0000_0000; // RULE4
		endcase
	end

	// Read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= nxt_prdata;
		end
	end

	// Ready asserts in the first cycle of the access phase, registered from setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
		end
	end

	// Combined and error interrupt outputs, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uart_irq  <= 1'b0;
			error_irq <= 1'b0;
		end else begin
			uart_irq  <= |(nxt_raw_status & mask_ff);
			error_irq <= |(nxt_raw_status & mask_ff & UISD_ERR_MASK);
		end
	end

	// DMA request gating
	uisd_dma_gate u_dma_gate (
		.pclk                  (pclk),
		.presetn               (presetn),
		.dma_ctrl              (dma_ctrl_ff),
		.error_irq             (error_irq), // RULE11
		.rx_single_raw         (rx_single_raw),
		.rx_burst_raw          (rx_burst_raw),
		.tx_single_raw         (tx_single_raw),
		.tx_burst_raw          (tx_burst_raw),
		.rx_dma_single_request (rx_dma_single_request),
		.rx_dma_burst_request  (rx_dma_burst_request),
		.tx_dma_single_request (tx_dma_single_request),
		.tx_dma_burst_request  (tx_dma_burst_request)
	);
endmodule : uisd_top

// *** uisd_top_properties.sv ***
`timescale 1ns/1ps
// Port-level checks of the status, interrupt and DMA request block
module uisd_top_properties (
	// Bus
	input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [31:0] prdata,
	// Sources, raw requests and outputs
	input wire logic        overrun_irq, break_irq, parity_irq, framing_irq,
	input wire logic        rx_single_raw, rx_burst_raw, tx_single_raw, tx_burst_raw,
	input wire logic        rx_dma_single_request, rx_dma_burst_request,
	input wire logic        tx_dma_single_request, tx_dma_burst_request, uart_irq, error_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answer timing and unused data bits
	property p_ready; psel && !penable |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_upper; pready && !pwrite |-> prdata[31:11] == 21'h0; endproperty
	// Interrupt outputs against their causes
	property p_err_sub; error_irq |-> uart_irq; endproperty
	property p_err_cause;
		$rose(error_irq) |-> $past(overrun_irq | break_irq | parity_irq | framing_irq)
			|| $past(psel && pwrite, 2);
	endproperty
	// Requests never appear without a raw request one cycle before
	property p_rxs; rx_dma_single_request |-> $past(rx_single_raw); endproperty
	property p_rxb; rx_dma_burst_request |-> $past(rx_burst_raw); endproperty
	property p_txs; tx_dma_single_request |-> $past(tx_single_raw); endproperty
	property p_txb; tx_dma_burst_request |-> $past(tx_burst_raw); endproperty
	a_ready: assert property (p_ready) else $error("no pready after setup");
	a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
	a_upper: assert property (p_upper) else $error("upper read bits not zero");
	a_err_sub: assert property (p_err_sub) else $error("error irq without irq");
	a_err_cause: assert property (p_err_cause) else $error("error irq no cause");
	a_rxs: assert property (p_rxs) else $error("rx single without raw");
	a_rxb: assert property (p_rxb) else $error("rx burst without raw");
	a_txs: assert property (p_txs) else $error("tx single without raw");
	a_txb: assert property (p_txb) else $error("tx burst without raw");
	c_irq: cover property ($rose(uart_irq));
	c_slv: cover property (pslverr);
	c_block: cover property (rx_single_raw && error_irq && !rx_dma_single_request);
endmodule : uisd_top_properties

// *** uisd_dma_model.sv ***
`timescale 1ns/1ps
// DMA controller stand-in: counts the request cycles it would service
module uisd_dma_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] req,
	output int              rx_cnt,
	output int              tx_cnt
);
	// Count cycles holding a receive or transmit request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_cnt <= 0;
			tx_cnt <= 0;
		end else begin
			rx_cnt <= rx_cnt + int'(req[3] | req[2]);
			tx_cnt <= tx_cnt + int'(req[1] | req[0]);
		end
	end
endmodule : uisd_dma_model

// *** uisd_top_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module uisd_top_tb_top;
	import uisd_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, uart_irq, error_irq;
	logic [10:0] src = '0, m;
	logic [4:0]  txl = 5'h08, rxl = 5'h08;
	logic [3:0]  raw = '0, req;
	logic [15:0] lfsr = 16'h0054;
	logic [11:0] ad [5] = '{UISD_ADDR_MASK, UISD_ADDR_RAW, UISD_ADDR_MASKED, UISD_ADDR_DMA,
	                        UISD_ADDR_CLEAR};
	int          num_errors = 0, samples_checked = 0, cyc = 0, rx_cnt, tx_cnt;
	uisd_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .overrun_irq(src[10]), .break_irq(src[9]), .parity_irq(src[8]),
		.framing_irq(src[7]), .rx_timeout_irq(src[6]), .dsr_change_irq(src[3]),
		.dcd_change_irq(src[2]), .cts_change_irq(src[1]), .ring_change_irq(src[0]),
		.tx_fill_level(txl), .rx_fill_level(rxl), .rx_single_raw(raw[3]),
		.rx_burst_raw(raw[2]), .tx_single_raw(raw[1]), .tx_burst_raw(raw[0]),
		.rx_dma_single_request(req[3]), .rx_dma_burst_request(req[2]),
		.tx_dma_single_request(req[1]), .tx_dma_burst_request(req[0]), .uart_irq, .error_irq);
	uisd_dma_model u_dma (.pclk, .presetn, .req, .rx_cnt, .tx_cnt);
	// Clock and run limit
	initial forever #10 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			print_verdict();
		end
	end
	function automatic logic [15:0] nxt_lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nxt_lfsr
	// Expected receive request pair for a control value and error state
	function automatic logic [1:0] exp_rx_dma(input int c, input logic err);
		return {2{c[UISD_BIT_RX_DMA_EN] & !(c[UISD_BIT_DMA_ON_ERR] & err)}};
	endfunction : exp_rx_dma
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	// One bus transfer; waits for pready, keeps read data and error flag
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata; slv = pslverr;
		psel <= 0; penable <= 0;
	endtask : apb
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, '0);
		`CHK($sformatf("read %h", a), e, rd)
	endtask : rdchk
	// Reset values of every readable register, clear register reads zero
	task automatic chk_reset();
		foreach (ad[i]) rdchk(ad[i], '0);
		rdchk(UISD_ADDR_FIFO_LVL, {26'h0, UISD_LVL_RESET});
	endtask : chk_reset
	// Raises one source; bits 5 and 4 through a fill level crossing
	task automatic fire(input int b);
		@(posedge pclk);
		if (b == 5) txl <= 5'h10; else if (b == 4) rxl <= 5'h00; else src[b] <= 1;
		@(posedge pclk);
		src <= '0; txl <= 5'h04; rxl <= 5'h0c;
		@(posedge pclk);
	endtask : fire
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		chk_reset();
		$display("test reset done");
		for (int b = 10; b >= 0; b--) begin
			lfsr = nxt_lfsr(lfsr);
			m = lfsr[10:0];
			apb(1, UISD_ADDR_MASK, {lfsr, lfsr});
			rdchk(UISD_ADDR_MASK, {21'h0, m});
			fire(b);
			rdchk(UISD_ADDR_RAW, 1 << b);
			rdchk(UISD_ADDR_MASKED, (1 << b) & m);
			`CHK("uart_irq", m[b], uart_irq)
			apb(1, UISD_ADDR_RAW, '1);
			apb(1, UISD_ADDR_MASKED, '0);
			apb(1, UISD_ADDR_CLEAR, ~(1 << b) & 32'h7ff);
			rdchk(UISD_ADDR_RAW, 1 << b);
			apb(1, UISD_ADDR_CLEAR, 1 << b);
			rdchk(UISD_ADDR_RAW, '0);
		end
		$display("test status done");
		// Transmit trigger at 2, receive trigger at 14; one event per crossing only
		apb(1, UISD_ADDR_FIFO_LVL, 32'hffe0);
		rdchk(UISD_ADDR_FIFO_LVL, 32'h20);
		txl <= 5'h02;
		rxl <= 5'h0e;
		rdchk(UISD_ADDR_RAW, 32'h30);
		apb(1, UISD_ADDR_CLEAR, 32'h30);
		rdchk(UISD_ADDR_RAW, '0);
		$display("test fifo level done");
		raw <= 4'hf;
		for (int e = 0; e < 2; e++) begin
			apb(1, UISD_ADDR_MASK, 32'h400);
			if (e == 1) fire(10);
			for (int c = 0; c < 8; c++) begin
				apb(1, UISD_ADDR_DMA, c | 32'hfff8);
				rdchk(UISD_ADDR_DMA, c);
				`CHK("rx dma", exp_rx_dma(c, e[0]), req[3:2])
				`CHK("tx dma", {2{c[1]}}, req[1:0])
				`CHK("error_irq", e[0], error_irq)
			end
			apb(1, UISD_ADDR_CLEAR, 32'h7ff);
		end
		`CHK("dma seen", 1'b1, rx_cnt > 0 && tx_cnt > 0)
		$display("test dma done");
		// Reset in mid-run with a status bit pending and DMA enabled
		fire(10);
		presetn <= 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		chk_reset();
		`CHK("dma after reset", 4'h0, req)
		$display("test mid reset done");
		rdchk(12'h100, '0);
		`CHK("pslverr", 1'b1, slv)
		$display("test unmapped done");
		print_verdict();
	end
endmodule : uisd_top_tb_top
bind uisd_top uisd_top_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
	.pready, .pslverr, .prdata, .overrun_irq, .break_irq, .parity_irq, .framing_irq,
	.rx_single_raw, .rx_burst_raw, .tx_single_raw, .tx_burst_raw, .rx_dma_single_request,
	.rx_dma_burst_request, .tx_dma_single_request, .tx_dma_burst_request, .uart_irq,
	.error_irq);
